// *** dcdec_pkg.sv ***
// Constants, command codes and carrier types of the display command decoder
// Functional notes
// - Opcode 00h stores panel setup byte, default 0Fh, and common-electrode float bit D4.
// - Opcode 01h stores supply enables 07h, gate level 01h, source levels 05h.
// - Opcode 02h has no parameters and pulses the supplies-off event.
// - Opcode 03h stores supply-off delay select in bits D5:D4, default 00h.
// - Opcode 04h has no parameters and pulses the supplies-on event.
// - Opcode 06h stores soft-start phases A, B and six-bit C, all default 00h.
// - Opcode 07h enters deep sleep only when the next byte is check value A5h.
// - Opcode 10h streams pixel bytes, two 3-bit codes in D6:D4 and D2:D0.
// - Opcode 11h ends data; next read byte reports data-received flag in D7.
// - Opcode 12h has no parameters and pulses the display refresh start.
// - Opcode 13h stores image-process enable D4 and type D2:D0, default 00h.
// - Opcode 20h takes a 220-byte common-electrode table, 11 bytes repeated 20 times.
// - Opcode 21h takes a 260-byte blue-transition table, 13 bytes repeated 20 times.
// - Opcode 22h takes a 260-byte white-transition table, 13 bytes repeated 20 times.
// - Select line (leading bit in 9-bit mode) low marks an opcode byte, high marks a parameter or data byte.
// - Busy output goes low while the engine works; host waits for it high.
// - Serial bits count only with chip select low; width select picks 8 or 9 bits.
package dcdec_pkg;

	// ****************************************
	// Command codes
	// ****************************************
	localparam logic [7:0] CMD_PANEL = 8'h00;
	localparam logic [7:0] CMD_SUPPLY = 8'h01;
	localparam logic [7:0] CMD_SUPPLY_OFF = 8'h02;
	localparam logic [7:0] CMD_OFF_DELAY = 8'h03;
	localparam logic [7:0] CMD_SUPPLY_ON = 8'h04;
	localparam logic [7:0] CMD_SOFTSTART = 8'h06;
	localparam logic [7:0] CMD_SLEEP = 8'h07;
	localparam logic [7:0] CMD_PIXEL_LOAD = 8'h10;
	localparam logic [7:0] CMD_DATA_STOP = 8'h11;
	localparam logic [7:0] CMD_REFRESH = 8'h12;
	localparam logic [7:0] CMD_IMAGE_PROC = 8'h13;
	localparam logic [7:0] CMD_VCOM_TABLE = 8'h20;
	localparam logic [7:0] CMD_BLUE_TABLE = 8'h21;
	localparam logic [7:0] CMD_WHITE_TABLE = 8'h22;
	localparam logic [7:0] SLEEP_CHECK = 8'hA5;

	// ****************************************
	// Field masks and positions
	// ****************************************
	localparam logic [7:0] PANEL_MASK = 8'hEF;
	localparam logic [7:0] HIZ_MASK = 8'h10;
	localparam logic [7:0] ENABLE_MASK = 8'h37;
	localparam logic [7:0] GATE_MASK = 8'h07;
	localparam logic [7:0] LEVEL_MASK = 8'h3F;
	localparam logic [7:0] OFF_DELAY_MASK = 8'h30;
	localparam logic [7:0] PHASE_C_MASK = 8'h3F;
	localparam logic [7:0] IMAGE_MASK = 8'h17;
	localparam int FLAG_BIT = 7;
	localparam int PIX_A_LSB = 4;
	localparam int PIX_B_LSB = 0;

	// ****************************************
	// Transfer lengths, opcode byte excluded
	// ****************************************
	localparam logic [8:0] VCOM_TABLE_LEN = 9'h0DC;
	localparam logic [8:0] COLOR_TABLE_LEN = 9'h104;
	localparam logic [3:0] LAST_BIT_4WIRE = 4'h7;
	localparam logic [3:0] LAST_BIT_3WIRE = 4'h8;

	// ****************************************
	// Types
	// ****************************************
	typedef enum logic [2:0] {
		PH_IDLE = 3'b000,
		PH_PARAM = 3'b001,
		PH_PIXEL = 3'b010,
		PH_TABLE = 3'b011,
		PH_READ = 3'b100
	} dcdec_phase_t;

	typedef enum logic [1:0] {
		KIND_PIXEL = 2'b00,
		KIND_VCOM = 2'b01,
		KIND_BLUE = 2'b10,
		KIND_WHITE = 2'b11
	} dcdec_kind_t;

	typedef struct packed {
		logic [7:0] panel_config;
		logic [7:0] panel_vcom_hiz;
		logic [7:0] supply_enables;
		logic [7:0] gate_level;
		logic [7:0] pos_source_level;
		logic [7:0] neg_source_level;
		logic [7:0] poweroff_delay;
		logic [7:0] softstart_phase_a;
		logic [7:0] softstart_phase_b;
		logic [7:0] softstart_phase_c;
		logic [7:0] image_process_cfg;
	} dcdec_cfg_t;

	localparam dcdec_cfg_t CFG_RESET = '{8'h0F, 8'h00, 8'h07, 8'h01, 8'h05, 8'h05,
		8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

	typedef struct packed {
		dcdec_kind_t kind;
		logic [7:0] data;
	} dcdec_item_t;

	typedef struct packed {
		dcdec_kind_t kind;
		logic [2:0] pix_a;
		logic [2:0] pix_b;
		logic [7:0] data;
	} dcdec_out_t;

endpackage

// *** dcdec_top.sv ***
// Command decoder of the display driver with its stream FIFO
`timescale 1ns/1ns

// ****************************************
// Stream FIFO
// ****************************************
module dcdec_fifo
	import dcdec_pkg::*;
#(
	parameter int WIDTH = 10,
	parameter int DEPTH = 16
)
(
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// Drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	typedef struct packed {
		logic [AW:0] wr;
		logic [AW:0] rd;
	} dcdec_fptr_t;

	dcdec_fptr_t st;
	dcdec_fptr_t next_st;
	logic [WIDTH-1:0] mem [DEPTH];
	logic full;
	logic empty;

	// Full when pointers differ only in the wrap bit
	assign full = (st.wr[AW] != st.rd[AW]) && (st.wr[AW-1:0] == st.rd[AW-1:0]);
	assign empty = (st.wr == st.rd);
	assign in_ready = !full;
	assign out_valid = !empty;
	assign out_data = mem[st.rd[AW-1:0]];

	// Pointer advance
	always_comb
	begin
		next_st = st;
		if (in_valid && !full)
		begin
			next_st.wr = st.wr + 1'b1;
		end
		if (out_ready && !empty)
		begin
			next_st.rd = st.rd + 1'b1;
		end
	end

	// Pointer registers
	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			st <= '0;
		end
		else
		begin
			st <= next_st;
		end
	end

	// Storage
	always_ff @(posedge clk)
	begin
		if (in_valid && !full)
		begin
			mem[st.wr[AW-1:0]] <= in_data;
		end
	end
endmodule

// ****************************************
// Command decoder
// ****************************************
module dcdec_top
	import dcdec_pkg::*;
#(
	parameter int FIFO_DEPTH = 16
)
(
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Serial pins
	input wire logic csn,
	input wire logic sclk,
	input wire logic dc,
	input wire logic serial_width_select,
	input wire logic sdio_in,
	output logic sdio_out,
	output logic sdio_oe,
	// Engine status and busy pin
	input wire logic engine_busy,
	output logic busy_n,
	// Settings and events
	output dcdec_cfg_t cfg,
	output logic supply_on,
	output logic supply_off,
	output logic refresh_start,
	output logic deep_sleep,
	// Pixel and table stream
	output logic out_valid,
	input wire logic out_ready,
	output dcdec_out_t out_item
);
	typedef struct packed {
		logic sclk_m;
		logic sclk_q;
		logic sclk_p;
		logic sdi_m;
		logic sdi_q;
		logic csn_m;
		logic csn_q;
		logic dc_m;
		logic dc_q;
		logic bs_m;
		logic bs_q;
		logic [3:0] nbit;
		logic [7:0] shreg;
		dcdec_phase_t phase;
		logic [7:0] op;
		logic [8:0] idx;
		logic [7:0] tx;
		logic flag;
		dcdec_cfg_t cfg;
		logic ev_on;
		logic ev_off;
		logic ev_ref;
		logic asleep;
		logic busy_n;
		logic sdo;
		logic sdo_oe;
		logic ovalid;
		dcdec_out_t oitem;
	} dcdec_state_t;

	dcdec_state_t st;
	dcdec_state_t next_st;
	logic rise;
	logic fall;
	logic byte_done;
	logic rx_data;
	logic [7:0] rx_byte;
	logic push;
	dcdec_item_t push_item;
	logic fifo_in_ready;
	logic fifo_out_valid;
	logic fifo_out_ready;
	dcdec_item_t fifo_out_data;

	// ****************************************
	// Next-state logic
	// ****************************************
	always_comb
	begin
		next_st = st;
		rise = st.sclk_q & ~st.sclk_p;
		fall = ~st.sclk_q & st.sclk_p;
		byte_done = 1'b0;
		rx_data = 1'b0;
		rx_byte = 8'h00;
		push = 1'b0;
		push_item = '0;
		next_st.ev_on = 1'b0;
		next_st.ev_off = 1'b0;
		next_st.ev_ref = 1'b0;
		// Two-stage synchronisers on every pin
		next_st.sclk_m = sclk;
		next_st.sclk_q = st.sclk_m;
		next_st.sclk_p = st.sclk_q;
		next_st.sdi_m = sdio_in;
		next_st.sdi_q = st.sdi_m;
		next_st.csn_m = csn;
		next_st.csn_q = st.csn_m;
		next_st.dc_m = dc;
		next_st.dc_q = st.dc_m;
		next_st.bs_m = serial_width_select;
		next_st.bs_q = st.bs_m;
		// Bit assembly, 8 bits plus pin or 9 bits with leading select bit
		if (st.csn_q)
		begin
			next_st.nbit = 4'h0;
			// A read cut by deselect must not swallow the next frame
			if (st.phase == PH_READ)
			begin
				next_st.phase = PH_IDLE;
			end
		end
		else if (rise)
		begin
			next_st.shreg = {st.shreg[6:0], st.sdi_q};
			if (st.phase == PH_READ)
			begin
				next_st.nbit = st.nbit + 4'h1;
				if (st.nbit == LAST_BIT_4WIRE)
				begin
					next_st.nbit = 4'h0;
					next_st.phase = PH_IDLE;
				end
			end
			else if (st.nbit == (st.bs_q ? LAST_BIT_3WIRE : LAST_BIT_4WIRE))
			begin
				byte_done = !st.asleep;
				next_st.nbit = 4'h0;
				rx_byte = {st.shreg[6:0], st.sdi_q};
				rx_data = st.bs_q ? st.shreg[7] : st.dc_q;
			end
			else
			begin
				next_st.nbit = st.nbit + 4'h1;
			end
		end
		// Shift only after a read bit, not on the opcode's own last fall
		else if (fall && st.phase == PH_READ && st.nbit != 4'h0)
		begin
			next_st.tx = {st.tx[6:0], 1'b0};
		end
		// Opcode byte
		if (byte_done && !rx_data)
		begin
			next_st.op = rx_byte;
			next_st.idx = 9'h000;
			next_st.phase = PH_IDLE;
			case (rx_byte)
				CMD_PANEL, CMD_SUPPLY, CMD_OFF_DELAY, CMD_SOFTSTART, CMD_SLEEP, CMD_IMAGE_PROC:
				begin
					next_st.phase = PH_PARAM;
				end
				CMD_SUPPLY_OFF: next_st.ev_off = 1'b1;
				CMD_SUPPLY_ON: next_st.ev_on = 1'b1;
				CMD_REFRESH: next_st.ev_ref = 1'b1;
				CMD_PIXEL_LOAD:
				begin
					next_st.phase = PH_PIXEL;
					next_st.flag = 1'b0;
				end
				CMD_DATA_STOP:
				begin
					next_st.phase = PH_READ;
					next_st.tx = 8'h00;
					next_st.tx[FLAG_BIT] = st.flag;
				end
				CMD_VCOM_TABLE, CMD_BLUE_TABLE, CMD_WHITE_TABLE:
				begin
					next_st.phase = PH_TABLE;
				end
				default: next_st.phase = PH_IDLE;
			endcase
		end
		// Parameter and data bytes
		else if (byte_done)
		begin
			if (st.idx != 9'h1FF)
			begin
				next_st.idx = st.idx + 9'h001;
			end
			case (st.phase)
				PH_PARAM:
				begin
					case (st.op)
						CMD_PANEL:
						begin
							if (st.idx == 9'h000)
							begin
								next_st.cfg.panel_config = rx_byte & PANEL_MASK;
							end
							if (st.idx == 9'h001)
							begin
								next_st.cfg.panel_vcom_hiz = rx_byte & HIZ_MASK;
							end
						end
						CMD_SUPPLY:
						begin
							case (st.idx)
								9'h000: next_st.cfg.supply_enables = rx_byte & ENABLE_MASK;
								9'h001: next_st.cfg.gate_level = rx_byte & GATE_MASK;
								9'h002: next_st.cfg.pos_source_level = rx_byte & LEVEL_MASK;
								9'h003: next_st.cfg.neg_source_level = rx_byte & LEVEL_MASK;
								default: next_st.cfg = st.cfg;
							endcase
						end
						CMD_OFF_DELAY:
						begin
							if (st.idx == 9'h000)
							begin
								next_st.cfg.poweroff_delay = rx_byte & OFF_DELAY_MASK;
							end
						end
						CMD_SOFTSTART:
						begin
							case (st.idx)
								9'h000: next_st.cfg.softstart_phase_a = rx_byte;
								9'h001: next_st.cfg.softstart_phase_b = rx_byte;
								9'h002: next_st.cfg.softstart_phase_c = rx_byte & PHASE_C_MASK;
								default: next_st.cfg = st.cfg;
							endcase
						end
						CMD_SLEEP:
						begin
							if (st.idx == 9'h000 && rx_byte == SLEEP_CHECK)
							begin
								next_st.asleep = 1'b1;
							end
						end
						CMD_IMAGE_PROC:
						begin
							if (st.idx == 9'h000)
							begin
								next_st.cfg.image_process_cfg = rx_byte & IMAGE_MASK;
							end
						end
						default: next_st.cfg = st.cfg;
					endcase
				end
				PH_PIXEL:
				begin
					push = fifo_in_ready;
					push_item = '{KIND_PIXEL, rx_byte};
					next_st.flag = 1'b1;
				end
				PH_TABLE:
				begin
					// Bytes past the table length are dropped
					if (st.op == CMD_VCOM_TABLE)
					begin
						push = fifo_in_ready && (st.idx < VCOM_TABLE_LEN);
						push_item = '{KIND_VCOM, rx_byte};
					end
					else
					begin
						push = fifo_in_ready && (st.idx < COLOR_TABLE_LEN);
						push_item = '{(st.op == CMD_BLUE_TABLE) ? KIND_BLUE : KIND_WHITE, rx_byte};
					end
				end
				default: next_st.idx = st.idx;
			endcase
		end
		// Read-back driver and busy pin
		next_st.sdo = next_st.tx[FLAG_BIT];
		next_st.sdo_oe = (next_st.phase == PH_READ) && !st.csn_q;
		next_st.busy_n = !(engine_busy || !fifo_in_ready);
		// Output stage of the stream
		if (fifo_out_valid && fifo_out_ready)
		begin
			next_st.ovalid = 1'b1;
			next_st.oitem.kind = fifo_out_data.kind;
			next_st.oitem.data = fifo_out_data.data;
			next_st.oitem.pix_a = fifo_out_data.data[PIX_A_LSB +: 3];
			next_st.oitem.pix_b = fifo_out_data.data[PIX_B_LSB +: 3];
		end
		else if (out_ready)
		begin
			next_st.ovalid = 1'b0;
		end
	end

	assign fifo_out_ready = !st.ovalid || out_ready;

	// ****************************************
	// State register
	// ****************************************
	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			st <= '0;
			st.csn_m <= 1'b1;
			st.csn_q <= 1'b1;
			st.cfg <= CFG_RESET;
			st.busy_n <= 1'b1;
		end
		else
		begin
			st <= next_st;
		end
	end

	dcdec_fifo #(
		.WIDTH($bits(dcdec_item_t)),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk(clk),
		.rstn(rstn),
		.in_valid(push),
		.in_ready(fifo_in_ready),
		.in_data(push_item),
		.out_valid(fifo_out_valid),
		.out_ready(fifo_out_ready),
		.out_data(fifo_out_data)
	);

	// Outputs from flops
	assign sdio_out = st.sdo;
	assign sdio_oe = st.sdo_oe;
	assign busy_n = st.busy_n;
	assign cfg = st.cfg;
	assign supply_on = st.ev_on;
	assign supply_off = st.ev_off;
	assign refresh_start = st.ev_ref;
	assign deep_sleep = st.asleep;
	assign out_valid = st.ovalid;
	assign out_item = st.oitem;

	// ****************************************
	// Assertions
	// ****************************************
	sequence s_op(logic [7:0] c);
		byte_done && !rx_data && rx_byte == c;
	endsequence

	sequence s_par(logic [7:0] c, logic [8:0] i);
		byte_done && rx_data && st.phase == PH_PARAM && st.op == c && st.idx == i;
	endsequence

	a_panel_store: assert property (@(posedge clk) disable iff (!rstn)
		s_par(CMD_PANEL, 9'h000) |=> cfg.panel_config == ($past(rx_byte) & PANEL_MASK))
		else $error("panel setup byte not stored");
	a_level_store: assert property (@(posedge clk) disable iff (!rstn)
		s_par(CMD_SUPPLY, 9'h003) |=> cfg.neg_source_level == ($past(rx_byte) & LEVEL_MASK))
		else $error("negative source level not stored");
	a_off_pulse: assert property (@(posedge clk) disable iff (!rstn)
		s_op(CMD_SUPPLY_OFF) |=> supply_off ##1 !supply_off)
		else $error("supply off pulse wrong");
	a_delay_store: assert property (@(posedge clk) disable iff (!rstn)
		s_par(CMD_OFF_DELAY, 9'h000) |=> cfg.poweroff_delay == ($past(rx_byte) & OFF_DELAY_MASK))
		else $error("off delay not stored");
	a_on_pulse: assert property (@(posedge clk) disable iff (!rstn)
		s_op(CMD_SUPPLY_ON) |=> supply_on ##1 !supply_on)
		else $error("supply on pulse wrong");
	a_sleep_check: assert property (@(posedge clk) disable iff (!rstn)
		s_par(CMD_SLEEP, 9'h000) ##0 (!deep_sleep && rx_byte != SLEEP_CHECK) |=> !deep_sleep)
		else $error("deep sleep without check byte");
	a_pixel_push: assert property (@(posedge clk) disable iff (!rstn)
		byte_done && rx_data && st.phase == PH_PIXEL && fifo_in_ready |-> push && push_item.data == rx_byte)
		else $error("pixel byte not queued");
	a_flag_read: assert property (@(posedge clk) disable iff (!rstn)
		s_op(CMD_DATA_STOP) |=> sdio_oe && sdio_out == $past(st.flag))
		else $error("data flag not driven");
	a_refresh_pulse: assert property (@(posedge clk) disable iff (!rstn)
		s_op(CMD_REFRESH) |=> refresh_start ##1 !refresh_start)
		else $error("refresh pulse wrong");
	a_table_limit: assert property (@(posedge clk) disable iff (!rstn)
		byte_done && st.phase == PH_TABLE && st.op == CMD_VCOM_TABLE && st.idx >= VCOM_TABLE_LEN |-> !push)
		else $error("table byte past length queued");
	a_busy_pin: assert property (@(posedge clk) disable iff (!rstn)
		engine_busy |=> !busy_n)
		else $error("busy not shown");
	a_new_opcode: assert property (@(posedge clk) disable iff (!rstn)
		byte_done && !rx_data |=> st.idx == 9'h000 && st.op == $past(rx_byte))
		else $error("opcode did not restart collection");
endmodule

// *** dcdec_host_model.sv ***
// Host model driving the serial command pins of the decoder
`timescale 1ns/1ns
module dcdec_host_model
(
	// Clock and device status
	input wire logic clk,
	input wire logic serial_width_select,
	input wire logic busy_n,
	input wire logic sdio_w,
	// Serial pins
	output logic csn,
	output logic sclk,
	output logic dc,
	output logic sdio_drv
);
	// ****************************************
	// Idle pins and framing
	// ****************************************
	// Deselected, link clock standing low
	initial
	begin
		csn = 1'b1;
		sclk = 1'b0;
		dc = 1'b0;
		sdio_drv = 1'b0;
	end

	// Chip select around a group of bytes
	task automatic frame(input logic sel);
		csn <= ~sel;
		repeat (4) @(posedge clk);
	endtask

	// ****************************************
	// Shifting
	// ****************************************
	// Bits MSB first, 320 ns link period
	task automatic send_bits(input logic [8:0] w, input int n);
		int i;
		for (i = n - 1; i >= 0; i--)
		begin
			sdio_drv <= w[i];
			repeat (4) @(posedge clk);
			sclk <= 1'b1;
			repeat (4) @(posedge clk);
			sclk <= 1'b0;
		end
		sdio_drv <= ~w[0]; // Released line shows the inverse
		repeat (4) @(posedge clk);
	endtask

	// One byte with its data or command marker
	task automatic send_byte(input logic isdat, input logic [7:0] b);
		int k;
		k = 0;
		while (busy_n !== 1'b1 && k < 4000)
		begin
			@(posedge clk);
			k++;
		end
		if (serial_width_select)
		begin
			dc <= ~isdat; // Pin must be ignored here
			send_bits({isdat, b}, 9);
		end
		else
		begin
			dc <= isdat;
			send_bits({1'b0, b}, 8);
		end
	endtask

	// Byte driven by the device, sampled before each rise
	task automatic read_byte(output logic [7:0] r);
		int i;
		repeat (4) @(posedge clk);
		for (i = 7; i >= 0; i--)
		begin
			@(negedge clk);
			r[i] = sdio_w;
			@(posedge clk);
			sclk <= 1'b1;
			repeat (4) @(posedge clk);
			sclk <= 1'b0;
			repeat (8) @(posedge clk);
		end
	endtask
endmodule

// *** tb.sv ***
// Self-checking bench of the display command decoder
`timescale 1ns/1ns
module tb
	import dcdec_pkg::*;
;
	logic clk, rstn, csn, sclk, dc, sdio_drv, sdio_w, serial_width_select;
	logic sdio_out, sdio_oe, engine_busy, busy_n, supply_on, supply_off, refresh_start;
	logic deep_sleep, out_valid, out_ready;
	logic [7:0] rd;
	dcdec_cfg_t cfg;
	dcdec_out_t out_item;
	dcdec_out_t got_q[$];
	logic [7:0] ops[5] = '{8'h00, 8'h01, 8'h03, 8'h06, 8'h13};
	logic [7:0] pulses[3] = '{8'h02, 8'h04, 8'h12};
	int cnt[5] = '{2, 4, 1, 3, 1};
	int err_total = 0, tests_run = 0, cyc = 0, n_on = 0, n_off = 0, n_ref = 0;
	int n, i, t, len;

	// ****************************************
	// Clock, wiring and monitors
	// ****************************************
	always #20 clk = ~clk;
	// Shared data line
	assign sdio_w = sdio_oe ? sdio_out : sdio_drv;

	dcdec_host_model i_host (.clk(clk), .serial_width_select(serial_width_select),
		.busy_n(busy_n), .sdio_w(sdio_w), .csn(csn), .sclk(sclk), .dc(dc),
		.sdio_drv(sdio_drv));

	dcdec_top #(.FIFO_DEPTH(16)) i_dut (.clk(clk), .rstn(rstn), .csn(csn), .sclk(sclk),
		.dc(dc), .serial_width_select(serial_width_select), .sdio_in(sdio_w),
		.sdio_out(sdio_out), .sdio_oe(sdio_oe), .engine_busy(engine_busy),
		.busy_n(busy_n), .cfg(cfg), .supply_on(supply_on), .supply_off(supply_off),
		.refresh_start(refresh_start), .deep_sleep(deep_sleep), .out_valid(out_valid),
		.out_ready(out_ready), .out_item(out_item));

	// Pulse counters, stream capture, hang limit
	always @(posedge clk)
	begin
		cyc++;
		n_on += (supply_on === 1'b1);
		n_off += (supply_off === 1'b1);
		n_ref += (refresh_start === 1'b1);
		if (out_valid === 1'b1 && out_ready === 1'b1)
			got_q.push_back(out_item);
		if (cyc == 80000)
		begin
			err_total++;
			$display("ERROR timeout expected 0 seen %0d", cyc);
			finish_test();
		end
	end

	// ****************************************
	// Helpers
	// ****************************************
	task automatic chk(input string nm, input logic [87:0] e, input logic [87:0] g);
		tests_run++;
		if (g !== e)
		begin
			err_total++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask

	function automatic logic [7:0] pix(input int k);
		return 8'(k * 59 + 9);
	endfunction

	// Captured words against kind and byte order
	task automatic check_words(input logic [1:0] k, input int c, input logic px);
		int q;
		logic [7:0] v;
		chk("word count", c, got_q.size());
		for (q = 0; q < got_q.size(); q++)
		begin
			v = px ? pix(q) : 8'(q);
			chk("word kind data", {k, v}, {got_q[q].kind, got_q[q].data});
			if (px)
				chk("word pixels", {v[6:4], v[2:0]}, {got_q[q].pix_a, got_q[q].pix_b});
		end
	endtask

	task automatic finish_test();
		$display("err_total=%0d tests_run=%0d", err_total, tests_run);
		if (err_total == 0 && tests_run > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// ****************************************
	// Main sequence
	// ****************************************
	initial
	begin
		clk = 1'b0;
		rstn = 1'b0;
		serial_width_select = 1'b0;
		engine_busy = 1'b0;
		out_ready = 1'b0;
		repeat (5) @(posedge clk);
		chk("cfg reset", 88'h0F00070105050000000000, cfg);
		rstn <= 1'b1;
		repeat (3) @(posedge clk);
		chk("busy_n idle", 1, busy_n);
		chk("idle outputs", 0, {out_valid, sdio_oe, deep_sleep});
		// Every setting command, one surplus byte each, both bus widths
		for (t = 0; t < 2; t++)
		begin
			serial_width_select <= t[0];
			i_host.frame(1'b1);
			for (i = 0; i < 5; i++)
			begin
				i_host.send_byte(1'b0, ops[i]);
				for (n = 0; n <= cnt[i]; n++)
					i_host.send_byte(1'b1, (n < cnt[i]) ^ t[0] ? 8'hFF : 8'h5A);
			end
			i_host.frame(1'b0);
			chk("cfg set", t ? 88'h4A1012021A1A105A5A1A12 : 88'hEF1037073F3F30FFFF3F17, cfg);
		end
		serial_width_select <= 1'b0;
		// Events, each followed by a stray data byte
		for (t = 0; t < 3; t++)
		begin
			i_host.frame(1'b1);
			i_host.send_byte(1'b0, pulses[t]);
			i_host.send_byte(1'b1, 8'h04);
			i_host.frame(1'b0);
			chk("pulses", {8'd1, 8'(t > 0), 8'(t > 1)}, {n_off[7:0], n_on[7:0], n_ref[7:0]});
		end
		// Half a byte cut off by chip select
		i_host.frame(1'b1);
		i_host.send_bits(9'h1FF, 4);
		i_host.frame(1'b0);
		i_host.frame(1'b1);
		i_host.send_byte(1'b0, 8'h04);
		i_host.frame(1'b0);
		chk("partial byte", 2, n_on);
		engine_busy <= 1'b1;
		repeat (3) @(posedge clk);
		chk("busy_n engine", 0, busy_n);
		engine_busy <= 1'b0;
		repeat (3) @(posedge clk);
		chk("busy_n free", 1, busy_n);
		// Pixels with the consumer stalled until the buffer refuses
		i_host.frame(1'b1);
		i_host.send_byte(1'b0, 8'h10);
		for (n = 0; n < 24 && busy_n !== 1'b0; n++)
		begin
			i_host.send_byte(1'b1, pix(n));
			repeat (6) @(posedge clk);
		end
		chk("fifo full", 1, n >= 16 && n <= 18);
		for (i = 0; i < 300 && got_q.size() < n; i++)
		begin
			out_ready <= ~out_ready;
			@(posedge clk);
		end
		out_ready <= 1'b1;
		check_words(2'd0, n, 1'b1);
		got_q.delete();
		i_host.send_byte(1'b0, 8'h11);
		chk("read enable", 1, sdio_oe);
		i_host.read_byte(rd);
		chk("flag set", 8'h80, rd);
		chk("read release", 0, sdio_oe);
		i_host.send_byte(1'b0, 8'h10);
		i_host.send_byte(1'b0, 8'h11);
		i_host.read_byte(rd);
		chk("flag clear", 8'h00, rd);
		i_host.frame(1'b0);
		// Three tables, one byte too many each
		for (t = 0; t < 3; t++)
		begin
			len = t ? 260 : 220;
			i_host.frame(1'b1);
			i_host.send_byte(1'b0, 8'h20 + 8'(t));
			for (i = 0; i <= len; i++)
				i_host.send_byte(1'b1, 8'(i));
			i_host.frame(1'b0);
			repeat (8) @(posedge clk);
			check_words(2'(t + 1), len, 1'b0);
			got_q.delete();
		end
		// Sleep with a wrong, then the right check byte
		i_host.frame(1'b1);
		i_host.send_byte(1'b0, 8'h07);
		i_host.send_byte(1'b1, 8'h5A);
		chk("sleep refused", 0, deep_sleep);
		i_host.send_byte(1'b0, 8'h07);
		i_host.send_byte(1'b1, 8'hA5);
		chk("sleep entered", 1, deep_sleep);
		i_host.send_byte(1'b0, 8'h04);
		i_host.frame(1'b0);
		repeat (8) @(posedge clk);
		chk("sleep ignores", 2, n_on);
		// Reset in mid-run leaves deep sleep and restores the defaults
		rstn <= 1'b0;
		repeat (5) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		chk("cfg after reset", 88'h0F00070105050000000000, cfg);
		chk("sleep after reset", 0, deep_sleep);
		repeat (2) @(posedge clk);
		i_host.frame(1'b1);
		i_host.send_byte(1'b0, 8'h04);
		i_host.frame(1'b0);
		chk("awake after reset", 3, n_on);
		finish_test();
	end
endmodule
